// ==== core/dtcl_core.sv ====
// display timer, control nibble and low supply logic on the nibble system bus
`timescale 1ns/10ps
`include "dtcl_map.svh"
module dtcl_core (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] bus_in,
    output logic [3:0] bus_out,
    output logic [3:0] bus_oe,
    input wire logic bus_strobe_low,
    input wire logic command_data_line_in,
    output logic command_data_line_out,
    output logic command_data_line_oe,
    input wire logic config_strap_low,
    input wire logic config_strap_high,
    input wire logic osc_in,
    input wire logic timer_clk_in,
    output logic timer_clk_out,
    output logic timer_clk_oe,
    output logic display_on_line_n,
    output logic display_on_line_oe,
    input wire logic low_supply_cmp,
    input wire logic very_low_supply_cmp
);
    import dtcl_pkg::*;

    logic [3:0] bus_q;
    logic stb_q, cd_q, osc_q, tclk_in_q, strap_lo_q, strap_hi_q, low_q, vlow_q;
    logic stb_prev_r, osc_prev_r, tick_prev_r;
    logic stb_fall, stb_rise, cmd_fall, data_fall, osc_rise, tick_src, tick;
    logic is_master, sel, is_timer, is_ctrl, srq;
    logic [3:0] chip_n, rd_nib;
    dtcl_mode_t mode_r;
    logic [19:0] addr_r;
    logic [2:0] load_cnt_r;
    logic [23:0] timer_r;
    logic display_on_r, blink_r, timer_en_r;
    logic sample_start_r, shutdown_r, woken_r;
    logic [4:0] div_cnt_r;
    logic low_flag, very_low_flag, sample_busy;

    // every pin from outside passes the three-stage synchroniser
    dtcl_sync #(.W(12)) u_sync (
        .clk(clk),
        .reset(reset),
        .d({bus_in, bus_strobe_low, command_data_line_in, osc_in, timer_clk_in,
            config_strap_low, config_strap_high, low_supply_cmp, very_low_supply_cmp}),
        .q({bus_q, stb_q, cd_q, osc_q, tclk_in_q, strap_lo_q, strap_hi_q, low_q, vlow_q})
    );

    dtcl_supply_sampler u_sampler (
        .clk(clk),
        .reset(reset),
        .start(sample_start_r),
        .low_cmp(low_q),
        .very_low_cmp(vlow_q),
        .low_flag(low_flag),
        .very_low_flag(very_low_flag),
        .busy(sample_busy)
    );

    // edge history of synchronised levels
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stb_prev_r <= 1'b0; // matches the synchroniser's reset level, so no false fall
            osc_prev_r <= 1'b0;
            tick_prev_r <= 1'b0;
        end else begin
            stb_prev_r <= stb_q;
            osc_prev_r <= osc_q;
            tick_prev_r <= tick_src;
        end
    end

    // strobe and crystal edges; command strobes have command_data_line low
    assign stb_fall = stb_prev_r & ~stb_q;
    assign stb_rise = ~stb_prev_r & stb_q;
    assign cmd_fall = stb_fall & ~cd_q;
    assign data_fall = stb_fall & cd_q;
    assign osc_rise = osc_q & ~osc_prev_r;

    // chip role and block decode
    assign is_master = strap_lo_q & strap_hi_q;
    assign chip_n = {2'b00, strap_hi_q, strap_lo_q};
    assign sel = (addr_r[19:12] == `DTCL_BLOCK_PREFIX) && (addr_r[11:8] == chip_n);
    assign is_timer = sel && addr_r[7:0] >= `DTCL_TIMER_FIRST && addr_r[7:0] <= `DTCL_TIMER_LAST;
    assign is_ctrl = sel && addr_r[7:0] == `DTCL_CTRL_OFFSET;
    assign srq = timer_r[`DTCL_TIMER_MSB] & timer_en_r;

    // read mux; slaves blank the supply flags since their comparators mean nothing
    always_comb begin
        rd_nib = 4'h0;
        if (is_ctrl) begin
            rd_nib[`DTCL_BIT_DISPLAY_ON] = display_on_r;
            rd_nib[`DTCL_BIT_BLINK] = blink_r;
            rd_nib[`DTCL_BIT_LOW_SUPPLY] = low_flag & is_master;
            rd_nib[`DTCL_BIT_VERY_LOW] = very_low_flag & is_master;
        end else if (is_timer) begin
            rd_nib = timer_r[addr_r[2:0]*4 +: 4];
        end
    end

    // command decode and address sequencing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_r <= dtcl_idle;
            addr_r <= 20'h00000;
            load_cnt_r <= 3'h0;
        end else if (cmd_fall) begin
            load_cnt_r <= 3'h0;
            case (bus_q)
                `DTCL_CMD_READ: mode_r <= dtcl_read;
                `DTCL_CMD_WRITE: mode_r <= dtcl_write;
                `DTCL_CMD_LOAD_ADDR: mode_r <= dtcl_load_addr;
                `DTCL_CMD_POLL: mode_r <= dtcl_poll;
                default: mode_r <= dtcl_idle;
            endcase
        end else if (data_fall) begin
            case (mode_r)
                dtcl_load_addr: begin
                    addr_r[load_cnt_r*4 +: 4] <= bus_q;
                    load_cnt_r <= 3'(load_cnt_r + 3'h1);
                    if (load_cnt_r == 3'(`DTCL_ADDR_NIBBLES - 3'h1)) begin
                        mode_r <= dtcl_idle;
                    end
                end
                dtcl_read, dtcl_write: addr_r <= 20'(addr_r + 20'h00001);
                dtcl_poll: mode_r <= dtcl_idle;
                default: mode_r <= dtcl_idle;
            endcase
        end
    end

    // bus drive: held from the strobe's fall until it rises again
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_out <= 4'h0;
            bus_oe <= 4'h0;
        end else if (data_fall && mode_r == dtcl_read && (is_timer || is_ctrl)) begin
            bus_out <= rd_nib;
            bus_oe <= 4'hf;
        end else if (data_fall && mode_r == dtcl_poll && srq) begin
            bus_out <= 4'h0;
            bus_oe <= 4'h1;
        end else if (stb_rise) begin
            bus_oe <= 4'h0;
        end
    end

    // control nibble writes; bit 2 has no write meaning
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            display_on_r <= 1'b0;
            blink_r <= 1'b0;
            timer_en_r <= 1'b0;
        end else if (data_fall && mode_r == dtcl_write && is_ctrl) begin
            display_on_r <= bus_q[`DTCL_BIT_DISPLAY_ON];
            blink_r <= bus_q[`DTCL_BIT_BLINK];
            timer_en_r <= bus_q[`DTCL_BIT_TIMER_EN];
        end
    end

    // each control read kicks the supply sampler
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sample_start_r <= 1'b0;
        end else begin
            sample_start_r <= data_fall && mode_r == dtcl_read && is_ctrl;
        end
    end

    // crystal divider: 32 crystal edges per half period gives 512 Hz
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_cnt_r <= 5'h00;
            timer_clk_out <= 1'b0;
            timer_clk_oe <= 1'b0;
        end else begin
            timer_clk_oe <= is_master;
            if (osc_rise) begin
                div_cnt_r <= 5'(div_cnt_r + 5'h01);
                if (div_cnt_r == `DTCL_OSC_HALF_LAST) begin
                    timer_clk_out <= ~timer_clk_out;
                end
            end
        end
    end

    // master counts on its own divider, slaves on the synchronised input clock
    assign tick_src = is_master ? timer_clk_out : tclk_in_q;
    assign tick = tick_src & ~tick_prev_r;

    // timer: a bus write wins over a coinciding tick, which is then lost
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timer_r <= `DTCL_TIMER_RESET;
        end else if (data_fall && mode_r == dtcl_write && is_timer) begin
            timer_r[addr_r[2:0]*4 +: 4] <= bus_q;
        end else if (tick) begin
            timer_r <= 24'(timer_r - 24'h000001);
        end
    end

    // shutdown lasts until the next strobe from the woken cpu
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shutdown_r <= 1'b0;
        end else if (cmd_fall && bus_q == `DTCL_CMD_SHUTDOWN) begin
            shutdown_r <= 1'b1;
        end else if (stb_fall) begin
            shutdown_r <= 1'b0;
        end
    end

    // wake pull; woken_r re-arms only once the request condition has dropped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            command_data_line_oe <= 1'b0;
            command_data_line_out <= 1'b0;
            woken_r <= 1'b0;
        end else begin
            command_data_line_out <= 1'b0;
            command_data_line_oe <= shutdown_r && !stb_fall &&
                (command_data_line_oe || (srq && !woken_r));
            woken_r <= srq && (woken_r || command_data_line_oe);
        end
    end

    // display on pin, active low, with blink gated by timer bit 8 (about 1 Hz)
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            display_on_line_n <= 1'b1;
            display_on_line_oe <= 1'b0;
        end else begin
            display_on_line_oe <= is_master;
            display_on_line_n <= ~(display_on_r &&
                (!blink_r || timer_r[`DTCL_BLINK_BIT]));
        end
    end

    sequence s_poll_cmd;
        cmd_fall && bus_q == `DTCL_CMD_POLL;
    endsequence
    sequence s_data_strobe_srq;
        data_fall && srq && mode_r == dtcl_poll;
    endsequence
    property p_poll_mode;
        @(posedge clk) disable iff (reset)
        s_poll_cmd |=> mode_r == dtcl_poll;
    endproperty
    a_poll_mode: assert property (p_poll_mode) else $error("poll command not taken");

    property p_poll_answer;
        @(posedge clk) disable iff (reset)
        s_data_strobe_srq |=> bus_oe == 4'h1 && !bus_out[0];
    endproperty
    a_poll_answer: assert property (p_poll_answer) else $error("poll not answered");

    property p_tick;
        @(posedge clk) disable iff (reset)
        tick && !(data_fall && mode_r == dtcl_write && is_timer)
            |=> timer_r == 24'($past(timer_r) - 24'h000001);
    endproperty
    a_tick: assert property (p_tick) else $error("timer did not decrement");

    property p_ctrl_read;
        @(posedge clk) disable iff (reset)
        data_fall && mode_r == dtcl_read && is_ctrl
            |=> bus_oe == 4'hf && bus_out[1:0] == {blink_r, display_on_r} && sample_start_r;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_slave_flags;
        @(posedge clk) disable iff (reset)
        data_fall && mode_r == dtcl_read && is_ctrl && !is_master |=> bus_out[3:2] == 2'b00;
    endproperty
    a_slave_flags: assert property (p_slave_flags) else $error("slave shows flags");

    property p_enable_write;
        @(posedge clk) disable iff (reset)
        data_fall && mode_r == dtcl_write && is_ctrl |=> timer_en_r == $past(bus_q[3]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not written");

    property p_wake;
        @(posedge clk) disable iff (reset)
        shutdown_r && srq && !woken_r && !stb_fall && !command_data_line_oe
            |=> command_data_line_oe ##1 woken_r;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake pull");

    property p_no_rewake;
        @(posedge clk) disable iff (reset)
        $rose(command_data_line_oe) |-> !$past(woken_r);
    endproperty
    a_no_rewake: assert property (p_no_rewake) else $error("woke twice");

    property p_slave_quiet;
        @(posedge clk) disable iff (reset)
        !is_master ##1 !is_master |-> !timer_clk_oe && !display_on_line_oe;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives master pins");
endmodule

// ==== core/dtcl_map.svh ====
// offsets, field positions, command codes and timing counts of the display timer block
`ifndef DTCL_MAP_SVH
`define DTCL_MAP_SVH

// address layout 2EnXX: block prefix in bits 19:12, chip nibble n in 11:8
`define DTCL_BLOCK_PREFIX 8'h2e
`define DTCL_TIMER_FIRST 8'hf8
`define DTCL_TIMER_LAST 8'hfd
`define DTCL_CTRL_OFFSET 8'hff
`define DTCL_ADDR_NIBBLES 3'h5

// control nibble fields
`define DTCL_BIT_DISPLAY_ON 0
`define DTCL_BIT_BLINK 1
`define DTCL_BIT_LOW_SUPPLY 2
`define DTCL_BIT_VERY_LOW 3
`define DTCL_BIT_TIMER_EN 3

// timer
`define DTCL_TIMER_MSB 23
`define DTCL_TIMER_RESET 24'h000000
`define DTCL_BLINK_BIT 8

// bus command codes, sent with command_data_line low
`define DTCL_CMD_READ 4'h2
`define DTCL_CMD_WRITE 4'h4
`define DTCL_CMD_LOAD_ADDR 4'h6
`define DTCL_CMD_POLL 4'ha
`define DTCL_CMD_SHUTDOWN 4'he

// timing: 25 MHz core clock, 32768 Hz crystal, 512 Hz timer clock
`define DTCL_CLK_MHZ 25
`define DTCL_SAMPLE_US 100
`define DTCL_SAMPLE_CYCLES (`DTCL_SAMPLE_US * `DTCL_CLK_MHZ)
`define DTCL_OSC_HALF_LAST 5'h1f

`endif

// ==== core/dtcl_pkg.sv ====
// types shared by the display timer block
package dtcl_pkg;
    typedef enum logic [2:0] {
        dtcl_idle,
        dtcl_load_addr,
        dtcl_read,
        dtcl_write,
        dtcl_poll
    } dtcl_mode_t;
endpackage

// ==== core/dtcl_sync.sv ====
// three-stage pin synchroniser; output moves once stages two and three agree
`timescale 1ns/10ps
module dtcl_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import dtcl_pkg::*;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1, s2, s3;
            // stage one feeds only stage two, keeping metastability away from logic
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1 <= d[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        q[i] <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule

// ==== core/dtcl_supply_sampler.sv ====
// supply level sampler: one sample window per start, flags updated at its end
`timescale 1ns/10ps
`include "dtcl_map.svh"
module dtcl_supply_sampler (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic low_cmp,
    input wire logic very_low_cmp,
    output logic low_flag,
    output logic very_low_flag,
    output logic busy
);
    import dtcl_pkg::*;

    localparam logic [11:0] LAST = 12'(`DTCL_SAMPLE_CYCLES - 1);
    logic [11:0] cnt_r;

    // a start during a window abandons it and begins afresh
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 12'h000;
            busy <= 1'b0;
        end else if (start) begin
            cnt_r <= 12'h000;
            busy <= 1'b1;
        end else if (busy) begin
            cnt_r <= 12'(cnt_r + 12'h001);
            if (cnt_r == LAST) begin
                busy <= 1'b0;
            end
        end
    end

    // flags only change when a full window has run
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            low_flag <= 1'b0;
            very_low_flag <= 1'b0;
        end else if (busy && !start && cnt_r == LAST) begin
            low_flag <= low_cmp;
            very_low_flag <= very_low_cmp;
        end
    end

    property p_flags_hold;
        @(posedge clk) disable iff (reset)
        !(busy && cnt_r == LAST && !start) |=> $stable(low_flag) && $stable(very_low_flag);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("supply flags moved mid sample");

    property p_restart;
        @(posedge clk) disable iff (reset)
        start |=> busy && cnt_r == 12'h000;
    endproperty
    a_restart: assert property (p_restart) else $error("sample did not restart");
endmodule

// ==== bench/dtcl_cpu_model.sv ====
// cpu side of the nibble bus: strobe cycles, address loads, nibble reads and writes
`timescale 1ns/10ps
`include "dtcl_map.svh"
module dtcl_cpu_model (
    input wire logic clk,
    input wire logic [3:0] dev_out,
    input wire logic [3:0] dev_oe,
    input wire logic dev_cd_oe,
    output logic [3:0] bus_lvl,
    output logic strobe_low,
    output logic cd_lvl
);
    logic [3:0] drv_r;
    logic [3:0] seen_oe;
    logic drv_en_r;
    logic cd_r;
    logic flip_r;

    initial begin
        drv_r = 4'h0;
        seen_oe = 4'h0;
        drv_en_r = 1'b0;
        cd_r = 1'b1;
        flip_r = 1'b0;
        strobe_low = 1'b1;
    end

    // released lines toggle every cycle so a missing drive never reads as a match
    always @(posedge clk) flip_r <= ~flip_r;

    // wired level: device drive wins, then cpu drive, else the toggling pattern
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bus_lvl[i] = dev_oe[i] ? dev_out[i] : (drv_en_r ? drv_r[i] : flip_r ^ i[0]);
        end
        cd_lvl = dev_cd_oe ? 1'b0 : cd_r;
    end

    // one strobe: set up 5 clk, low 7 clk, sample at the rising edge, high 5 clk
    task automatic xfer(input logic cd, input logic en, input logic [3:0] nib,
                        output logic [3:0] got);
        cd_r <= cd;
        drv_en_r <= en;
        drv_r <= nib;
        repeat (5) @(posedge clk);
        strobe_low <= 1'b0;
        repeat (7) @(posedge clk);
        got = bus_lvl;
        seen_oe = dev_oe;
        strobe_low <= 1'b1;
        repeat (5) @(posedge clk);
    endtask

    // address load, least significant nibble first
    task automatic load(input logic [19:0] a);
        logic [3:0] g;
        xfer(1'b0, 1'b1, `DTCL_CMD_LOAD_ADDR, g);
        for (int i = 0; i < 5; i++) xfer(1'b1, 1'b1, a[4*i +: 4], g);
    endtask

    task automatic rd(input logic [19:0] a, input int n, output logic [23:0] v);
        logic [3:0] g;
        load(a);
        xfer(1'b0, 1'b1, `DTCL_CMD_READ, g);
        v = 24'h0;
        for (int i = 0; i < n; i++) begin
            xfer(1'b1, 1'b0, 4'h0, g);
            v[4*i +: 4] = g;
        end
    endtask

    task automatic wr(input logic [19:0] a, input int n, input logic [23:0] v);
        logic [3:0] g;
        load(a);
        xfer(1'b0, 1'b1, `DTCL_CMD_WRITE, g);
        for (int i = 0; i < n; i++) xfer(1'b1, 1'b1, v[4*i +: 4], g);
    endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench of the display timer block with a cpu bus model
`timescale 1ns/10ps
`include "dtcl_map.svh"
module tb_top;
    logic clk;
    logic reset;
    logic [3:0] bus_in;
    logic [3:0] bus_out;
    logic [3:0] bus_oe;
    logic strobe_low;
    logic cd_in;
    logic cd_out;
    logic cd_oe;
    logic strap_lo;
    logic strap_hi;
    logic osc;
    logic tclk_out;
    logic tclk_oe;
    logic don_n;
    logic don_oe;
    logic low_cmp;
    logic vlow_cmp;
    logic [2:0] osc_cnt;
    int error_cnt;
    int checked;

    initial clk = 1'b0;
    always #20 clk = ~clk;

    // crystal sped up to one period per 16 clk; the divide ratio is what is judged
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 3'h1;
        if (osc_cnt == 3'h7) osc <= ~osc;
    end

    dtcl_cpu_model cpu (.clk(clk), .dev_out(bus_out), .dev_oe(bus_oe), .dev_cd_oe(cd_oe),
        .bus_lvl(bus_in), .strobe_low(strobe_low), .cd_lvl(cd_in));

    // the dut's own timer clock loops back in as the clock a master would send a slave
    dtcl_core dut (.clk(clk), .reset(reset), .bus_in(bus_in), .bus_out(bus_out),
        .bus_oe(bus_oe), .bus_strobe_low(strobe_low), .command_data_line_in(cd_in),
        .command_data_line_out(cd_out), .command_data_line_oe(cd_oe),
        .config_strap_low(strap_lo), .config_strap_high(strap_hi), .osc_in(osc),
        .timer_clk_in(tclk_out), .timer_clk_out(tclk_out), .timer_clk_oe(tclk_oe),
        .display_on_line_n(don_n), .display_on_line_oe(don_oe),
        .low_supply_cmp(low_cmp), .very_low_supply_cmp(vlow_cmp));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // control writes and readback; bit 2 writes are dropped, bit 3 reads a flag
    task automatic t_ctrl();
        logic [23:0] v;
        int n;
        cpu.wr(20'h2e3ff, 1, 24'ha);
        chk({don_n, don_oe, tclk_oe}, 3'h7);
        cpu.rd(20'h2e3ff, 1, v);
        chk(v, 24'h2);
        cpu.wr(20'h2e3ff, 1, 24'h9);
        chk(don_n, 1'b0);
        cpu.wr(20'h2e3ff, 1, 24'hf);
        cpu.rd(20'h2e3ff, 1, v);
        chk(v, 24'h3);
        // half period is 32 crystal periods of 16 clk; pass a low phase to time a whole high one
        n = 0;
        while (tclk_out !== 1'b0 && n < 2000) begin @(posedge clk); n++; end
        n = 0;
        while (tclk_out === 1'b0 && n < 2000) begin @(posedge clk); n++; end
        n = 0;
        while (tclk_out === 1'b1 && n < 2000) begin @(posedge clk); n++; end
        chk(n, 512);
    endtask

    // flags change only when a full undisturbed sample window has run
    task automatic t_supply();
        logic [23:0] v;
        low_cmp <= 1'b1;
        vlow_cmp <= 1'b1;
        cpu.rd(20'h2e3ff, 1, v);
        repeat (200) @(posedge clk);
        cpu.rd(20'h2e3ff, 1, v);
        chk(v, 24'h3);
        repeat (2300) @(posedge clk);
        cpu.rd(20'h2e3ff, 1, v);
        chk(v, 24'h3);
        repeat (2600) @(posedge clk);
        cpu.rd(20'h2e3ff, 1, v);
        chk(v, 24'hf);
    endtask

    // safe load right after a tick, double read, then two ticks wrap the count
    task automatic t_timer();
        logic [23:0] a;
        logic [23:0] b;
        int n;
        cpu.rd(20'h2e3f8, 1, a);
        n = 0;
        b = a;
        while (b === a && n < 20) begin cpu.rd(20'h2e3f8, 1, b); n++; end
        cpu.wr(20'h2e3f8, 6, 24'h000001);
        cpu.rd(20'h2e3f8, 6, a);
        cpu.rd(20'h2e3f8, 6, b);
        chk(b, a);
        chk(a, 24'h000001);
        repeat (1500) @(posedge clk);
        cpu.rd(20'h2e3f8, 6, a);
        chk(a, 24'hffffff);
    endtask

    // timed out and enabled: poll answer, one wake, re-arm by clearing enable
    task automatic t_wake();
        logic [3:0] g;
        cpu.xfer(1'b0, 1'b1, `DTCL_CMD_POLL, g);
        cpu.xfer(1'b1, 1'b0, 4'h0, g);
        chk({cpu.seen_oe[0], g[0]}, 2'h2);
        cpu.xfer(1'b0, 1'b1, `DTCL_CMD_SHUTDOWN, g);
        repeat (5) @(posedge clk);
        chk({cd_oe, cd_out}, 2'h2);
        cpu.xfer(1'b0, 1'b1, `DTCL_CMD_SHUTDOWN, g);
        repeat (20) @(posedge clk);
        chk(cd_oe, 1'b0);
        cpu.wr(20'h2e3ff, 1, 24'h3);
        cpu.wr(20'h2e3ff, 1, 24'hb);
        repeat (10) @(posedge clk);
        chk(cd_oe, 1'b0);
        cpu.xfer(1'b0, 1'b1, `DTCL_CMD_SHUTDOWN, g);
        repeat (5) @(posedge clk);
        chk(cd_oe, 1'b1);
        cpu.wr(20'h2e3ff, 1, 24'h3);
        cpu.xfer(1'b0, 1'b1, `DTCL_CMD_POLL, g);
        cpu.xfer(1'b1, 1'b0, 4'h0, g);
        chk(cpu.seen_oe[0], 1'b0);
    endtask

    // secondary chip: no clock or display drive, flags carry nothing
    task automatic t_slave();
        logic [23:0] v;
        logic [23:0] a;
        strap_hi <= 1'b0;
        repeat (10) @(posedge clk);
        chk({tclk_oe, don_oe}, 2'h0);
        cpu.rd(20'h2e1ff, 1, v);
        repeat (2700) @(posedge clk);
        cpu.rd(20'h2e1ff, 1, v);
        chk(v[3:2], 2'h0);
        // two reads exactly one tick period apart see one decrement from the input clock
        cpu.rd(20'h2e1f8, 1, a);
        repeat (888) @(posedge clk);
        cpu.rd(20'h2e1f8, 1, v);
        chk(v[3:0], 4'(a[3:0] - 4'h1));
    endtask

    initial begin
        reset = 1'b1;
        osc = 1'b0;
        osc_cnt = 3'h0;
        strap_lo = 1'b1;
        strap_hi = 1'b1;
        low_cmp = 1'b0;
        vlow_cmp = 1'b0;
        error_cnt = 0;
        checked = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (10) @(posedge clk);
        t_ctrl();
        t_supply();
        t_timer();
        t_wake();
        t_slave();
        complete_run();
    end

    // cut a hang short well beyond the longest expected run
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule
